//--- design/rcd_top.sv
// Purpose: command path of a registering clock driver: power-down, clock stop,
//          MRS inversion and 3T handling, control-word writes, AHB-Lite access
// Assumes: pins are asynchronous and pass two flops; clock_stopped_in comes
//          from a detector that sees the input clock pair held low
// Notes on behaviour
// - Power-down keeps enable, termination receivers
// - Receivers off within disable delay
// - Parity receiver stays on one clock longer
// - Clocks run, CKE low, others off
// - Command outputs float after output float delay
// - Exit drives matching CKE and selects high
// - Fixed output levels during fixed output time
// - Selects held high one clock on exit
// - Clock stop floats all but CKE low
// - Outputs follow inputs within activation time
// - Inversion on after reset, B side complemented
// - MRS disables inversion, delays its select
// - 3T holds command outputs three cycles
// - Inversion returns three clocks after last MRS
// - Control-word write decoded from rank selects
// - Sixteen four-bit words, index and data fields
// - Parity checked, failing write discarded
// - Power-saving word picks termination variant
//
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
`include "rcd_defines.svh"
module rcd_top (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        clock_stopped_in,
   input  wire logic [1:0]  clock_enable_in,
   input  wire logic [1:0]  termination_ctl_in,
   input  wire logic [3:0]  rank_select_in,
   input  wire logic [15:0] addr_in,
   input  wire logic [2:0]  bank_addr_in,
   input  wire logic        row_strobe_in,
   input  wire logic        column_strobe_in,
   input  wire logic        write_enable_in,
   input  wire logic        parity_in,
   output logic [1:0]       clock_enable_out,
   output logic [1:0]       termination_ctl_out,
   output logic [3:0]       rank_select_out,
   output logic             row_strobe_out,
   output logic             column_strobe_out,
   output logic             write_enable_out,
   output logic [15:0]      addr_out,
   output logic [2:0]       bank_out,
   output logic [15:0]      b_side_addr_out,
   output logic [2:0]       b_side_bank_out,
   output logic             cmd_oe,
   output logic             dram_clock_run,
   output logic             cmd_rx_en,
   output logic             parity_rx_en,
   output logic             termination_rx_en,
   output logic             input_termination_en,
   output logic             parity_error_out_o,
   output logic             parity_error_out_oe
);
   // Count of low bits, used for select decoding
   function automatic logic [2:0] rcd_lows(input logic [3:0] v);
      rcd_lows = 3'(!v[0]) + 3'(!v[1]) + 3'(!v[2]) + 3'(!v[3]);
   endfunction

   logic [31:0]         pin_q;
   logic [1:0]          s_cke;
   logic [1:0]          s_odt;
   logic [3:0]          s_cs;
   rcd_pkg::rcd_cmd_t   s_cmd;
   logic                s_par;
   logic                s_stop;
   logic [63:0]         cw;
   rcd_pkg::rcd_cw_wr_t cw_wr;
   rcd_pkg::rcd_cw_wr_t pend_r;
   rcd_pkg::rcd_state_t state_r;
   rcd_pkg::rcd_state_t state_nxt;
   logic [7:0]          cnt_r;
   logic [7:0]          cnt_nxt;
   logic [1:0]          cke_prev_r;
   logic [1:0]          mrs_cnt_r;
   logic [1:0]          mrs_cnt_nxt;
   logic                mrs_fwd_r;
   logic [3:0]          mrs_cs_r;
   logic [1:0]          hold_r;
   logic [1:0]          err_cnt_r;
   logic                chk_r;
   logic                par_d_r;
   logic                inv_r;
   logic                inv_nxt;
   rcd_pkg::rcd_cmd_t   cmd_r;
   rcd_pkg::rcd_cmd_t   cmd_nxt;
   logic [3:0]          cs_r;
   logic [3:0]          cs_nxt;
   logic [1:0]          cke_out_r;
   logic [1:0]          odt_r;
   logic [15:0]         b_addr_r;
   logic [2:0]          b_bank_r;
   logic                ctrl_quad_r;
   logic                ap_wr_r;
   logic [7:0]          ap_addr_r;
   logic [31:0]         rdata_r;

   // Every pin passes two flops before use
   rcd_sync #(
      .W   (32),
      .RST (`RCD_PIN_RST)
   ) u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .d       ({clock_stopped_in, parity_in, write_enable_in, column_strobe_in,
                 row_strobe_in, bank_addr_in, addr_in, rank_select_in,
                 termination_ctl_in, clock_enable_in}),
      .q       (pin_q)
   );
   assign s_cke  = pin_q[1:0];
   assign s_odt  = pin_q[3:2];
   assign s_cs   = pin_q[7:4];
   assign s_cmd  = rcd_pkg::rcd_cmd_t'({pin_q[27], pin_q[28], pin_q[29],
                                        pin_q[23:8], pin_q[26:24]});
   assign s_par  = pin_q[30];
   assign s_stop = pin_q[31];

   // Control word store
   rcd_cw_file u_cw (
      .hclk    (hclk),
      .hresetn (hresetn),
      .wr      (cw_wr),
      .words   (cw)
   );

   // Fields of the words that steer this block
   wire [3:0] rc_inv = cw[`RCD_RC_INV*4 +: 4];
   wire [3:0] rc_tim = cw[`RCD_RC_TIM*4 +: 4];
   wire [3:0] rc_pwr = cw[`RCD_RC_PWR*4 +: 4];
   wire       pd_en   = rc_pwr[`RCD_CW_PD_EN];
   wire       term_off = rc_pwr[`RCD_CW_TERM_OFF];
   wire       tim_3t  = rc_tim[`RCD_CW_3T];

   // Select decoding; in two-rank mode the upper selects read as idle
   wire [3:0] eff_cs   = ctrl_quad_r ? s_cs : {2'b11, s_cs[1:0]};
   wire [2:0] cs_lows  = rcd_lows(eff_cs);
   wire       cw_sel   = ctrl_quad_r ? (s_cs == 4'h3 || s_cs == 4'h0)
                                     : (s_cs[1:0] == 2'h0);
   wire       run      = (state_r == rcd_pkg::RCD_RUN);
   wire       one_cs   = (cs_lows == 3'h1) && !cw_sel;
   wire       mrs_dec  = run && one_cs && !s_cmd.row_strobe &&
                         !s_cmd.column_strobe && !s_cmd.write_enable;
   wire       cw_ok    = run && cw_sel && (s_cmd.addr[15:5] == 11'h000) && |s_cke;
   wire       hold_act = (hold_r != 2'h0);

   // Parity lags data by one clock; deselected cycles are not checked
   wire       par_err  = chk_r && (par_d_r ^ s_par) && parity_rx_en;

   assign cw_wr.en   = pend_r.en && !par_err;
   assign cw_wr.idx  = pend_r.idx;
   assign cw_wr.data = pend_r.data;

   // Power-down entry needs a high to low edge on the pair
   wire enter_pd = run && pd_en && (s_cke == 2'h0) && (cke_prev_r != 2'h0);
   wire in_pd    = (state_r == rcd_pkg::RCD_PD);
   wire in_stop  = (state_r == rcd_pkg::RCD_STOP);
   wire in_exit  = (state_r == rcd_pkg::RCD_EXIT);

   // Mode sequencing
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         rcd_pkg::RCD_RUN: begin
            if (s_stop) begin
               state_nxt = rcd_pkg::RCD_STOP;
            end else if (enter_pd) begin
               state_nxt = rcd_pkg::RCD_PD;
            end
         end
         rcd_pkg::RCD_PD: begin
            if (s_stop) begin
               state_nxt = rcd_pkg::RCD_STOP;
            end else if (|s_cke) begin
               state_nxt = rcd_pkg::RCD_EXIT;
            end
         end
         rcd_pkg::RCD_EXIT: begin
            if (s_stop) begin
               state_nxt = rcd_pkg::RCD_STOP;
            end else if (cnt_r >= `RCD_FIXED_CLKS - 8'h01) begin
               state_nxt = rcd_pkg::RCD_RUN;
            end
         end
         rcd_pkg::RCD_STOP: begin
            if (!s_stop && cnt_r >= `RCD_ACT_CLKS - 8'h01) begin
               state_nxt = rcd_pkg::RCD_RUN;
            end
         end
      endcase
   end

   // Counter restarts on each mode change and while the clock is held stopped
   assign cnt_nxt = (state_nxt != state_r || (in_stop && s_stop)) ? 8'h00 :
                    (cnt_r == 8'hFF) ? cnt_r : cnt_r + 8'h01;

   assign cmd_rx_en = !(in_stop || (in_pd && cnt_r >= `RCD_IN_DIS_CLKS));
   assign parity_rx_en = !(in_stop || (in_pd && cnt_r >= `RCD_IN_DIS_CLKS + 8'h01));
   assign termination_rx_en = !(in_stop || (in_pd && term_off &&
                                cnt_r >= `RCD_IN_DIS_CLKS));
   assign input_termination_en = !(in_stop || ((in_pd || in_exit) && term_off));
   assign cmd_oe = !(in_stop || (in_pd && cnt_r >= `RCD_QDIS_CLKS));
   assign dram_clock_run = !in_stop;

   assign mrs_cnt_nxt = mrs_dec ? `RCD_MRS_GAP :
                        (mrs_cnt_r != 2'h0) ? mrs_cnt_r - 2'h1 : 2'h0;
   assign inv_nxt = !rc_inv[`RCD_CW_INV_OFF] && (mrs_cnt_nxt == 2'h0);

   // Command and address outputs
   always_comb begin
      cmd_nxt = cmd_r;
      if (state_nxt == rcd_pkg::RCD_EXIT) begin
         cmd_nxt.row_strobe    = 1'b1;
         cmd_nxt.column_strobe = 1'b1;
         cmd_nxt.write_enable  = 1'b1;
         cmd_nxt.addr          = `RCD_FIXED_ADDR;
         cmd_nxt.bank          = 3'h0;
      end else if (run && !hold_act && !cw_sel && cs_lows != 3'h3) begin
         cmd_nxt = s_cmd;
      end
   end

   // Rank select outputs
   always_comb begin
      cs_nxt = eff_cs;
      // high for the first exit cycle only
      if ((state_nxt != rcd_pkg::RCD_RUN && !(in_exit && state_nxt == rcd_pkg::RCD_EXIT)) ||
          in_pd || in_stop) begin
         cs_nxt = 4'hF;
      end else if (cw_sel || cs_lows == 3'h3) begin
         cs_nxt = 4'hF;
      end else if (mrs_dec) begin
         cs_nxt = 4'hF;
      end else if (mrs_fwd_r) begin
         cs_nxt = mrs_cs_r;
      end
   end

   // Mode state and timers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r    <= rcd_pkg::RCD_RUN;
         cnt_r      <= 8'h00;
         cke_prev_r <= 2'h0;
         mrs_cnt_r  <= 2'h0;
         inv_r      <= 1'b1;
      end else begin
         state_r    <= state_nxt;
         cnt_r      <= cnt_nxt;
         cke_prev_r <= s_cke;
         mrs_cnt_r  <= mrs_cnt_nxt;
         inv_r      <= inv_nxt;
      end
   end

   // MRS forwarding and 3T hold
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mrs_fwd_r <= 1'b0;
         mrs_cs_r  <= 4'hF;
         hold_r    <= 2'h0;
      end else begin
         mrs_fwd_r <= mrs_dec;
         mrs_cs_r  <= eff_cs;
         if (run && one_cs && tim_3t && !hold_act) begin
            hold_r <= `RCD_HOLD_3T;
         end else if (hold_act) begin
            hold_r <= hold_r - 2'h1;
         end
      end
   end

   // Parity pipeline and pending control-word write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chk_r     <= 1'b0;
         par_d_r   <= 1'b0;
         pend_r    <= '0;
         err_cnt_r <= 2'h0;
      end else begin
         chk_r      <= run && (one_cs || cw_sel);
         par_d_r    <= ^s_cmd;
         pend_r.en   <= cw_ok;
         pend_r.idx  <= {s_cmd.bank[2], s_cmd.addr[2:0]};
         pend_r.data <= {s_cmd.bank[1:0], s_cmd.addr[4:3]};
         if (par_err) begin
            err_cnt_r <= `RCD_ERR_HOLD;
         end else if (err_cnt_r != 2'h0) begin
            err_cnt_r <= err_cnt_r - 2'h1;
         end
      end
   end

   // Output registers toward the DRAM ranks
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_r     <= '0;
         cs_r      <= 4'hF;
         cke_out_r <= 2'h0;
         odt_r     <= 2'h0;
         b_addr_r  <= 16'h0000;
         b_bank_r  <= 3'h0;
      end else begin
         cmd_r     <= cmd_nxt;
         cs_r      <= cs_nxt;
         cke_out_r <= (state_nxt == rcd_pkg::RCD_STOP) ? 2'h0 : s_cke;
         odt_r     <= (state_nxt == rcd_pkg::RCD_STOP ||
                       (state_nxt != rcd_pkg::RCD_RUN && term_off)) ? 2'h0 : s_odt;
         b_addr_r  <= cmd_nxt.addr ^ (inv_nxt ? `RCD_INV_ADDR : 16'h0000);
         b_bank_r  <= cmd_nxt.bank ^ (inv_nxt ? `RCD_INV_BANK : 3'h0);
      end
   end

   assign clock_enable_out    = cke_out_r;
   assign termination_ctl_out = odt_r;
   assign rank_select_out     = cs_r;
   assign row_strobe_out      = cmd_r.row_strobe;
   assign column_strobe_out   = cmd_r.column_strobe;
   assign write_enable_out    = cmd_r.write_enable;
   assign addr_out            = cmd_r.addr;
   assign bank_out            = cmd_r.bank;
   assign b_side_addr_out     = b_addr_r;
   assign b_side_bank_out     = b_bank_r;
   // Open drain: pulled low only, released otherwise
   assign parity_error_out_o  = 1'b0;
   assign parity_error_out_oe = (err_cnt_r != 2'h0);

   // AHB-Lite slave: zero wait states, always OKAY
   wire ap_take = hsel && hready && htrans[1];
   wire [31:0] status_word = {26'h0, tim_3t, pd_en, parity_error_out_oe, inv_r,
                              state_r};
   wire [31:0] rsel = (haddr[7:0] == `RCD_OFS_CTRL)   ? {31'h0, ctrl_quad_r} :
                      (haddr[7:0] == `RCD_OFS_STATUS) ? status_word :
                      (haddr[7:0] == `RCD_OFS_CW_LO)  ? cw[31:0] :
                      (haddr[7:0] == `RCD_OFS_CW_HI)  ? cw[63:32] : 32'h0000_0000;
   wire hit_hi = (haddr[31:8] == 24'h00_0000);

   // Address phase capture; read data is sampled here for the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_wr_r   <= 1'b0;
         ap_addr_r <= 8'h00;
         rdata_r   <= 32'h0000_0000;
      end else if (hready) begin
         ap_wr_r   <= ap_take && hwrite && hit_hi && (hsize == 3'h2);
         ap_addr_r <= haddr[7:0];
         rdata_r   <= (ap_take && !hwrite && hit_hi) ? rsel : 32'h0000_0000;
      end
   end

   // Data phase write of the control register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_quad_r <= `RCD_CTRL_RST;
      end else if (ap_wr_r && ap_addr_r == `RCD_OFS_CTRL) begin
         ctrl_quad_r <= hwdata[`RCD_CTRL_QUAD];
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_r;
endmodule

//--- pkg/rcd_defines.svh
// Purpose: constants of the command-path control (offsets, fields, resets, counts)
// Assumes: 10 MHz hclk; clock counts are in input clock periods
// Notes:   included by bare name from every design file except the pin synchroniser
`ifndef RCD_DEFINES_SVH
`define RCD_DEFINES_SVH

// Register byte offsets on the AHB-Lite slave
`define RCD_OFS_CTRL    8'h00
`define RCD_OFS_STATUS  8'h04
`define RCD_OFS_CW_LO   8'h08
`define RCD_OFS_CW_HI   8'h0C

// Control register fields and reset value
`define RCD_CTRL_QUAD   0
`define RCD_CTRL_RST    1'h0

// Control word indices and bit positions inside a word
`define RCD_RC_INV      4'h0
`define RCD_RC_TIM      4'h2
`define RCD_RC_PWR      4'h9
`define RCD_CW_INV_OFF  0
`define RCD_CW_3T       0
`define RCD_CW_TERM_OFF 2
`define RCD_CW_PD_EN    3
`define RCD_CW_RST      4'h0

// Pin synchroniser reset image: rank selects idle high
`define RCD_PIN_RST     32'h0000_00F0

// Timing: clock period and activation time in ns, other counts in clocks
`define RCD_CLK_NS      32'd100
`define RCD_IN_DIS_CLKS 8'h02
`define RCD_QDIS_CLKS   8'h01
`define RCD_FIXED_CLKS  8'h04
`define RCD_ACT_NS      32'd1000
`define RCD_ACT_CLKS    8'(`RCD_ACT_NS / `RCD_CLK_NS)
`define RCD_MRS_GAP     2'h3
`define RCD_HOLD_3T     2'h2
`define RCD_ERR_HOLD    2'h2

// Output inversion masks for the B side, and the fixed exit address
`define RCD_INV_ADDR    16'hEBF8
`define RCD_INV_BANK    3'h7
`define RCD_FIXED_ADDR  16'h0000
`endif

//--- pkg/rcd_pkg.sv
// Purpose: types shared by the command-path control
// Assumes: nothing
// Notes:   no constants here, see rcd_defines.svh
package rcd_pkg;
   typedef enum logic [1:0] {
      RCD_RUN  = 2'h0,
      RCD_PD   = 2'h1,
      RCD_STOP = 2'h3,
      RCD_EXIT = 2'h2
   } rcd_state_t;

   typedef struct packed {
      logic        row_strobe;
      logic        column_strobe;
      logic        write_enable;
      logic [15:0] addr;
      logic [2:0]  bank;
   } rcd_cmd_t;

   typedef struct packed {
      logic       en;
      logic [3:0] idx;
      logic [3:0] data;
   } rcd_cw_wr_t;
endpackage

//--- design/rcd_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: single clock hclk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ns
module rcd_sync #(
   parameter int          W   = 32,
   parameter logic [31:0] RST = 32'h0000_0000
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;

   // Metastability guard
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_r <= RST[W-1:0];
         s2_r <= RST[W-1:0];
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
      end
   end
   assign q = s2_r;
endmodule

//--- design/rcd_cw_file.sv
// Purpose: sixteen four-bit control words
// Assumes: write already checked for parity by the caller
// Notes:   only reset clears the words, a stopped clock keeps them
`timescale 1ns/1ns
`include "rcd_defines.svh"
module rcd_cw_file (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire rcd_pkg::rcd_cw_wr_t wr,
   output logic [63:0]             words
);
   logic [3:0] mem_r [0:15];

   genvar g;
   generate
      for (g = 0; g < 16; g++) begin : g_word
         // One word per slot, written by index
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               mem_r[g] <= `RCD_CW_RST;
            end else if (wr.en && wr.idx == 4'(g)) begin
               mem_r[g] <= wr.data;
            end
         end
         assign words[g*4 +: 4] = mem_r[g];
      end
   endgenerate
endmodule

//--- tb/rcd_top_sva.sv
// Purpose: port assertions for the command-path control
// Assumes: one clock hclk, hresetn asynchronous active low
// Notes:   attached by the bind at the foot of this file
`timescale 1ns/1ns
`include "rcd_defines.svh"
module rcd_top_sva (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic [1:0]  clock_enable_out,
   input wire logic [3:0]  rank_select_out,
   input wire logic [15:0] addr_out,
   input wire logic [2:0]  bank_out,
   input wire logic [15:0] b_side_addr_out,
   input wire logic [2:0]  b_side_bank_out,
   input wire logic        cmd_oe,
   input wire logic        dram_clock_run,
   input wire logic        cmd_rx_en,
   input wire logic        parity_rx_en,
   input wire logic        parity_error_out_oe
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Receivers go off only after outputs have floated, parity lingers
   chk_rx_after_float: assert property (
      $fell(cmd_rx_en) && dram_clock_run |-> $past(!cmd_oe)) else $error("receivers off early");
   chk_parity_rx_lag: assert property (
      $fell(cmd_rx_en) && dram_clock_run |-> parity_rx_en) else $error("parity receiver off early");
   chk_pd_cke_low: assert property (
      !cmd_rx_en && dram_clock_run |-> clock_enable_out == 2'h0 && !cmd_oe)
      else $error("power-down outputs wrong");
   chk_float_after_cke: assert property (
      $fell(cmd_oe) && dram_clock_run |-> clock_enable_out == 2'h0) else $error("float before cke low");
   // Exit from power-down shows all selects high first
   chk_exit_selects_high: assert property (
      $rose(|clock_enable_out) && $past(!cmd_oe) |-> rank_select_out == 4'hF)
      else $error("select low on exit");
   chk_clock_stop_float: assert property (
      !dram_clock_run [*2] |-> clock_enable_out == 2'h0 && !cmd_oe) else $error("clock stop outputs");
   // B side is either the masked complement or an exact copy
   chk_inversion_mask: assert property (
      (b_side_addr_out == (addr_out ^ `RCD_INV_ADDR) && b_side_bank_out == (bank_out ^ `RCD_INV_BANK))
      || (b_side_addr_out == addr_out && b_side_bank_out == bank_out)) else $error("bad inversion");
   chk_error_min_two: assert property (
      $rose(parity_error_out_oe) |=> parity_error_out_oe) else $error("error pulse too short");
endmodule

bind rcd_top rcd_top_sva i_sva (.*);

//--- tb/rcd_ctrl_model.sv
// Purpose: memory controller model driving the command pins
// Assumes: tasks are called from the bench
// Notes:   parity trails its command by one clock, as the device expects
`timescale 1ns/1ns
module rcd_ctrl_model (
   input  wire logic         hclk,
   output logic [1:0]        clock_enable_in,
   output logic [1:0]        termination_ctl_in,
   output logic [3:0]        rank_select_in,
   output rcd_pkg::rcd_cmd_t cmd,
   output logic              parity_in,
   output logic              clock_stopped_in
);
   // Idle is a NOP with every select high and the clock running
   initial begin
      clock_enable_in = 2'h3;
      termination_ctl_in = 2'h1;
      rank_select_in = 4'hF;
      cmd = '{1'b1, 1'b1, 1'b1, 16'h0000, 3'h0};
      parity_in = 1'b1;
      clock_stopped_in = 1'b0;
   end
   // one select cycle, then NOPs so commands stay six apart
   task send(input logic [3:0] sel, input rcd_pkg::rcd_cmd_t c, input logic flip);
      @(posedge hclk);
      rank_select_in <= sel;
      cmd <= c;
      @(posedge hclk);
      rank_select_in <= 4'hF;
      parity_in <= (^c) ^ flip;
      cmd <= '{1'b1, 1'b1, 1'b1, 16'h0000, 3'h0};
      @(posedge hclk);
      parity_in <= 1'b1;
      repeat (3) @(posedge hclk);
   endtask
   // callers lower CKE before the clock stops and keep selects high
   task set_pins(input logic [1:0] k, input logic stop);
      @(posedge hclk);
      clock_enable_in <= k;
      clock_stopped_in <= stop;
   endtask
endmodule

//--- tb/test_rcd_powerdown_mrs_ctrlword.sv
// Purpose: self-checking bench for the command-path control
// Assumes: 10 MHz hclk, pins pass two sync flops
// Notes:   expected values come from the masks and the status layout
`timescale 1ns/1ns
`include "rcd_defines.svh"
module test_rcd_powerdown_mrs_ctrlword;
   logic              hclk = 1'b0;
   logic              hresetn = 1'b0;
   logic              hsel = 1'b0, hwrite = 1'b0;
   logic [31:0]       haddr = 32'h0000_0000, hwdata = 32'h0000_0000, r;
   logic [1:0]        htrans = 2'h0;
   logic [2:0]        hsize = 3'h2;
   logic              hready, hreadyout, hresp, row_strobe_out, column_strobe_out;
   logic              write_enable_out, cmd_oe, dram_clock_run, cmd_rx_en, parity_rx_en;
   logic              termination_rx_en, input_termination_en, parity_error_out_o;
   logic              parity_error_out_oe, parity_in, clock_stopped_in;
   logic [31:0]       hrdata;
   logic [1:0]        clock_enable_in, termination_ctl_in, clock_enable_out, termination_ctl_out;
   logic [3:0]        rank_select_in, rank_select_out, seen_cs, next_cs;
   logic [15:0]       addr_out, b_side_addr_out, seen_b;
   logic [2:0]        bank_out, b_side_bank_out, seen_bb;
   rcd_pkg::rcd_cmd_t cmd;
   int                fail_count = 0;
   int                check_count = 0;

   // Single slave, so its ready is the bus ready
   assign hready = hreadyout;
   always #50 hclk = ~hclk;

   rcd_top i_dut (.*, .addr_in(cmd.addr), .bank_addr_in(cmd.bank),
      .row_strobe_in(cmd.row_strobe), .column_strobe_in(cmd.column_strobe),
      .write_enable_in(cmd.write_enable));
   rcd_ctrl_model i_ctrl (.*);

   task summarize;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task timeout(input string what);
      fail_count++;
      $display("CHECK FAILED %s expected event seen none", what);
      summarize;
   endtask
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Ready sampled at negedge to avoid races
   task wait_rdy;
      int n;
      logic rdy;
      n = 0;
      do begin
         @(negedge hclk);
         r = hrdata;
         rdy = hreadyout;
         @(posedge hclk);
         n++;
      end while (rdy !== 1'b1 && n < 20);
      if (rdy !== 1'b1) timeout("hready");
   endtask
   task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
   endtask
   // Catch a short output and the select after it
   task catch_cmd(input logic [15:0] a);
      int n;
      for (n = 0; n < 12 && addr_out !== a; n++) @(negedge hclk);
      if (n == 12) timeout("command out");
      seen_b = b_side_addr_out;
      seen_bb = b_side_bank_out;
      seen_cs = rank_select_out;
      @(negedge hclk);
      next_cs = rank_select_out;
   endtask
   task wait_pin(input logic [1:0] want, input int sel);
      int n;
      for (n = 0; n < 20 && (sel ? {1'b0, dram_clock_run} : clock_enable_out) !== want; n++)
         @(negedge hclk);
      if (n == 20) timeout("pin");
   endtask

   task t_reset;
      ahb(1'b0, `RCD_OFS_STATUS, 0);
      chk("status", 32'h4, r);
      ahb(1'b0, `RCD_OFS_CW_LO, 0);
      chk("words", 32'h0, r);
      ahb(1'b0, 32'h10, 0);
      chk("unmapped", 32'h0, r);
      $display("reset test done");
   endtask
   task t_mrs;
      fork
         i_ctrl.send(4'hE, '{1'b0, 1'b1, 1'b1, 16'hFFFF, 3'h7}, 1'b0);
         catch_cmd(16'hFFFF);
      join
      chk("b addr", 32'h1407, seen_b);
      chk("b bank", 32'h0, seen_bb);
      fork
         i_ctrl.send(4'hE, '{1'b0, 1'b0, 1'b0, 16'hFFFF, 3'h7}, 1'b0);
         catch_cmd(16'hFFFF);
      join
      chk("mrs b addr", 32'hFFFF, seen_b);
      chk("mrs select", 32'hF, seen_cs);
      chk("mrs select late", 32'hE, next_cs);
      fork
         i_ctrl.send(4'hE, '{1'b0, 1'b1, 1'b1, 16'hFFFF, 3'h7}, 1'b0);
         catch_cmd(16'hFFFF);
      join
      chk("reinverted", 32'h1407, seen_b);
      $display("mrs test done");
   endtask
   task t_cw;
      i_ctrl.send(4'hC, '{1'b1, 1'b1, 1'b1, 16'h0001, 3'h6}, 1'b0);
      ahb(1'b0, `RCD_OFS_CW_HI, 0);
      chk("word 9", 32'h80, r);
      fork
         i_ctrl.send(4'hC, '{1'b1, 1'b1, 1'b1, 16'h0008, 3'h0}, 1'b1);
         for (int n = 0; n < 12 && parity_error_out_oe !== 1'b1; n++) @(negedge hclk);
      join
      chk("error", 32'h1, parity_error_out_oe);
      ahb(1'b0, `RCD_OFS_CW_LO, 0);
      chk("discarded", 32'h0, r);
      $display("control word test done");
   endtask
   task t_pd;
      i_ctrl.set_pins(2'h0, 1'b0);
      repeat (8) @(negedge hclk);
      chk("cke out", 32'h0, clock_enable_out);
      chk("cmd oe", 32'h0, cmd_oe);
      chk("cmd rx", 32'h0, cmd_rx_en);
      chk("odt follows", 32'h1, termination_ctl_out);
      chk("termination", 32'h1, input_termination_en);
      ahb(1'b0, `RCD_OFS_STATUS, 0);
      chk("pd status", 32'h15, r);
      i_ctrl.set_pins(2'h3, 1'b0);
      wait_pin(2'h3, 0);
      chk("exit selects", 32'hF, rank_select_out);
      repeat (6) @(posedge hclk);
      i_ctrl.set_pins(2'h0, 1'b0);
      repeat (4) @(posedge hclk);
      i_ctrl.set_pins(2'h0, 1'b1);
      repeat (6) @(negedge hclk);
      chk("clock run", 32'h0, dram_clock_run);
      chk("stop cke", 32'h0, clock_enable_out);
      i_ctrl.set_pins(2'h0, 1'b0);
      wait_pin(2'h1, 1);
      i_ctrl.set_pins(2'h3, 1'b0);
      repeat (16) @(posedge hclk);
      ahb(1'b0, `RCD_OFS_STATUS, 0);
      chk("run again", 32'h14, r);
      $display("power-down test done");
   endtask
   task t_quad;
      logic [3:0]  sel [3] = '{4'h3, 4'h1, 4'h0};
      logic [15:0] adr [3] = '{16'h000A, 16'h0002, 16'h0002};
      logic [31:0] exp [3] = '{32'h34, 32'h34, 32'h14};
      ahb(1'b1, `RCD_OFS_CTRL, 32'h1);
      for (int i = 0; i < 3; i++) begin
         i_ctrl.send(sel[i], '{1'b1, 1'b1, 1'b1, adr[i], 3'h0}, 1'b0);
         ahb(1'b0, `RCD_OFS_STATUS, 0);
         chk("four-rank status", exp[i], r);
         if (i == 0) begin
            fork
               i_ctrl.send(4'hE, '{1'b0, 1'b1, 1'b1, 16'hFFFF, 3'h7}, 1'b0);
               catch_cmd(16'hFFFF);
            join_any
            chk("3T hold", 32'hFFFF, addr_out);
            @(negedge hclk);
            chk("3T third", 32'hFFFF, addr_out);
            @(negedge hclk);
            chk("3T end", 32'h0, addr_out);
            wait fork;
         end
      end
      $display("four-rank test done");
   endtask

   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      t_reset;
      t_mrs;
      t_cw;
      t_pd;
      t_quad;
      summarize;
   end
endmodule
